/* verilog/ptcf_pkg.sv */
// Constants and types shared by the PCI target port and its reset splitter.
// Behaviour
// RL1: Four reset sources, higher ranks reset more; the code splits six sources.
// RL2: EEPROM load after alternate, PCI, bus_n_a only.
// RL3: MAC config cleared except by selective reset.
// RL4: Pointers and micromachine reset except by bus_n_a.
// RL5: Config registers reset by hardware sources only; the code also resets them on d3_to_d0_in.
// RL6: PM events: alternate always, PCI without aux.
// RL7: Register and flash spaces decoded separately.
// RL8: Register space holds the control register groups.
// RL9: Register accesses complete with zero wait states.
// RL10: Register read: TRDY with data, then STOP.
// RL11: Register write: TRDY, single phase, STOP.
// RL12: Initiator drives bus, write data with IRDY.
// RL13: Transfer only when IRDY and TRDY both low.
// RL14: Flash accesses disconnect at the first phase.
// RL15: Flash read waits for flash, then TRDY.
// RL16: Flash reads are byte or word wide.
// RL17: Flash write holds TRDY until written.
// RL18: Flash writes are byte wide only.
// RL19: Flash window spans 128 Kbyte.
// RL20: Retry configuration cycles until EEPROM loaded.
// RL21: Configuration accesses also end with disconnect.
// RL22: Unclaimed addresses outside windows get no DEVSEL.
package ptcf_pkg;
  // PCI bus commands on C/BE#
  localparam logic [3:0] PTCF_CMD_IO_RD  = 4'h2;
  localparam logic [3:0] PTCF_CMD_IO_WR  = 4'h3;
  localparam logic [3:0] PTCF_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PTCF_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PTCF_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PTCF_CMD_CFG_WR = 4'hB;
  // Window sizes as address widths
  localparam int PTCF_CSR_MEM_AW = 12;  // 4 Kbyte
  localparam int PTCF_CSR_IO_AW  = 6;   // 64 byte
  localparam int PTCF_FLASH_AW   = 17;  // 128 Kbyte
  // Register space word index width
  localparam int PTCF_CSR_WORDS_AW = 4;
  // Flash access wait in clocks
  localparam int PTCF_FLASH_WAIT_NS = 250;
  localparam int PTCF_CLK_NS        = 50;
  localparam int PTCF_FLASH_WAIT    =
    (PTCF_FLASH_WAIT_NS + PTCF_CLK_NS - 1) / PTCF_CLK_NS;
  localparam int PTCF_CNT_W = 4;
  // Byte enable patterns, active low
  localparam logic [3:0] PTCF_BE_NONE = 4'hF;
  // Target state machine, Gray codes
  typedef enum logic [2:0] {
    PTCF_IDLE  = 3'b000,
    PTCF_DATA  = 3'b001,
    PTCF_FWAIT = 3'b011,
    PTCF_DONE  = 3'b010,
    PTCF_TURN  = 3'b110
  } ptcf_state_t;
  // Kind of claimed access
  typedef enum logic [1:0] {
    PTCF_K_CSR   = 2'b00,
    PTCF_K_FLASH = 2'b01,
    PTCF_K_CFG   = 2'b11
  } ptcf_kind_t;
endpackage : ptcf_pkg

/* verilog/ptcf_regmem.sv */
// Small register-space memory with registered read data.
`timescale 1ns/1ns
module ptcf_regmem #(
  parameter int AW = 4
) (
  input  wire logic          clk_sys_in,    // Bus clock
  input  wire logic          we_in,         // Write strobe
  input  wire logic [AW-1:0] addr_in,       // Word index
  input  wire logic [31:0]   wdata_in,      // Write data
  input  wire logic [3:0]    be_n_in,       // Byte enables, active low
  output logic      [31:0]   rdata_out      // Registered read data
);
  // Storage words
  logic [31:0] mem_reg [2**AW];
  // Byte-lane write and registered read
  always_ff @(posedge clk_sys_in) begin
    for (int b = 0; b < 4; b++) begin
      if (we_in && !be_n_in[b]) begin
        mem_reg[addr_in][b*8 +: 8] <= wdata_in[b*8 +: 8];
      end
    end
    rdata_out <= mem_reg[addr_in];
  end
endmodule : ptcf_regmem

/* verilog/ptcf_target.sv */
// PCI target port with register space, flash window and reset splitter.
`timescale 1ns/1ns
module ptcf_target #(
  parameter int FLASH_WAIT = ptcf_pkg::PTCF_FLASH_WAIT
) (
  input  wire logic        clk_sys_in,       // PCI clock
  input  wire logic        rst_in,           // PCI reset, active high
  input  wire logic        alternate_reset_n_in, // Alternate reset pin
  input  wire logic        bus_n_a_in,       // Bus_n_a pin, active low
  input  wire logic        d3_to_d0_in,      // Power state wake pulse
  input  wire logic        sw_reset_in,      // Software reset pulse
  input  wire logic        sel_reset_in,     // Selective reset pulse
  input  wire logic        aux_power_in,     // Auxiliary power present
  input  wire logic        eeprom_done_in,   // EEPROM load finished
  input  wire logic [31:0] csr_mem_base_in,  // Register memory BAR
  input  wire logic [31:0] csr_io_base_in,   // Register I/O BAR
  input  wire logic [31:0] flash_base_in,    // Flash BAR
  input  wire logic        idsel_in,         // Config select
  input  wire logic        frame_n_in,       // FRAME#
  input  wire logic        irdy_n_in,        // IRDY#
  input  wire logic [3:0]  cbe_n_in,         // C/BE#
  input  wire logic [31:0] ad_in,            // AD in
  output logic      [31:0] ad_out,           // AD out
  output logic             ad_oe_out,        // AD drive enable
  output logic             trdy_n_out,       // TRDY#
  output logic             stop_n_out,       // STOP#
  output logic             devsel_n_out,     // DEVSEL#
  output logic             ctl_oe_out,       // Target control enable
  input  wire logic [15:0] flash_rdata_in,   // Flash read data
  output logic      [16:0] flash_addr_out,   // Flash address
  output logic      [7:0]  flash_wdata_out,  // Flash write data
  output logic             flash_oe_n_out,   // Flash output enable
  output logic             flash_we_n_out,   // Flash write enable
  output logic      [31:0] cfg_rdata_out,    // Config read data
  output logic             eeprom_load_out,  // Start EEPROM load
  output logic             mac_cfg_rst_out,  // MAC config, hash clear
  output logic             ptr_rst_out,      // Pointers, micromachine
  output logic             pci_cfg_rst_out,  // Config register reset
  output logic             pm_evt_rst_out    // PM event clear
);
  import ptcf_pkg::*;

  // Register state
  typedef struct packed {
    ptcf_state_t           st;
    ptcf_kind_t            kind;
    logic                  wr;
    logic [31:0]           addr;
    logic [PTCF_CNT_W-1:0] cnt;
    logic [31:0]           dout;
    logic                  oe;
    logic                  trdy_n;
    logic                  stop_n;
    logic                  devsel_n;
    logic                  ctl_oe;
    logic [16:0]           faddr;
    logic [7:0]            fwdata;
    logic                  foe_n;
    logic                  fwe_n;
    logic                  frame_q;
    logic [1:0]            alt_sync;
    logic [1:0]            iso_sync;
  } ptcf_s_t;

  ptcf_s_t s_reg;   // Current state
  ptcf_s_t s_next;  // Next state

  logic [31:0] mem_rdata;   // Register memory read data
  logic        mem_we;      // Register memory write strobe
  logic        hit_csr_mem; // Address falls in register memory window
  logic        hit_csr_io;  // Address falls in register I/O window
  logic        hit_flash;   // Address falls in flash window
  logic        hit_cfg;     // Configuration cycle for us
  logic        addr_phase;  // FRAME# fell this cycle
  logic        xfer;        // Data transfer this cycle
  logic        alt_rst;     // Synchronised alternate reset
  logic        iso_rst;     // Synchronised bus_n_a
  logic [PTCF_CSR_WORDS_AW-1:0] mem_addr; // Word looked up this cycle

  // Synchronised pin levels, second stage only
  assign alt_rst = !s_reg.alt_sync[1];
  assign iso_rst = !s_reg.iso_sync[1];

  // Reset fan-out by source rank
  always_comb begin
    eeprom_load_out = alt_rst || rst_in || iso_rst;            // [RL2]
    mac_cfg_rst_out = alt_rst || rst_in || iso_rst ||
                      d3_to_d0_in || sw_reset_in;              // [RL3] [RL1]
    ptr_rst_out     = alt_rst || rst_in || d3_to_d0_in ||
                      sw_reset_in || sel_reset_in;             // [RL4] [RL1]
    pci_cfg_rst_out = alt_rst || rst_in || iso_rst ||
                      d3_to_d0_in;                             // [RL5]
    pm_evt_rst_out  = alt_rst || (rst_in && !aux_power_in);   // [RL6]
  end

  // Window decode, two separate spaces
  always_comb begin
    addr_phase  = !frame_n_in && s_reg.frame_q;
    hit_csr_mem = (cbe_n_in == PTCF_CMD_MEM_RD ||
                   cbe_n_in == PTCF_CMD_MEM_WR) &&
                  (ad_in[31:PTCF_CSR_MEM_AW] ==
                   csr_mem_base_in[31:PTCF_CSR_MEM_AW]);       // [RL7]
    hit_csr_io  = (cbe_n_in == PTCF_CMD_IO_RD ||
                   cbe_n_in == PTCF_CMD_IO_WR) &&
                  (ad_in[31:PTCF_CSR_IO_AW] ==
                   csr_io_base_in[31:PTCF_CSR_IO_AW]);         // [RL7]
    hit_flash   = (cbe_n_in == PTCF_CMD_MEM_RD ||
                   cbe_n_in == PTCF_CMD_MEM_WR) &&
                  (ad_in[31:PTCF_FLASH_AW] ==
                   flash_base_in[31:PTCF_FLASH_AW]);           // [RL19]
    hit_cfg     = idsel_in && (cbe_n_in == PTCF_CMD_CFG_RD ||
                               cbe_n_in == PTCF_CMD_CFG_WR);
    xfer        = !irdy_n_in && !s_reg.trdy_n;                 // [RL13]
  end

  // Register memory write when a write phase completes
  assign mem_we = xfer && s_reg.wr && (s_reg.kind == PTCF_K_CSR);

  // Word index from AD in the address phase, so the registered
  // read data is ready for the zero-wait data phase
  assign mem_addr = addr_phase ? ad_in[2 +: PTCF_CSR_WORDS_AW] :
                    s_reg.addr[2 +: PTCF_CSR_WORDS_AW];        // [RL9]

  // Register space storage, host command, port, flash, EEPROM, PHY
  ptcf_regmem #(.AW(PTCF_CSR_WORDS_AW)) u_regmem (               // [RL8]
    .clk_sys_in (clk_sys_in),
    .we_in      (mem_we),
    .addr_in    (mem_addr),
    .wdata_in   (ad_in),
    .be_n_in    (cbe_n_in),
    .rdata_out  (mem_rdata)
  );

  // Target sequencing
  always_comb begin
    s_next          = s_reg;
    s_next.frame_q  = frame_n_in;
    s_next.alt_sync = {s_reg.alt_sync[0], alternate_reset_n_in};
    s_next.iso_sync = {s_reg.iso_sync[0], bus_n_a_in};
    unique case (s_reg.st)
      // Claim on address phase, unclaimed stays quiet
      PTCF_IDLE: begin
        s_next.oe = 1'b0;
        if (addr_phase) begin
          s_next.addr = ad_in;
          s_next.wr   = cbe_n_in[0];
          s_next.cnt  = '0;
          if (hit_cfg) begin
            s_next.kind     = PTCF_K_CFG;
            s_next.devsel_n = 1'b0;
            s_next.ctl_oe   = 1'b1;
            s_next.st       = PTCF_DATA;
          end else if (hit_csr_mem || hit_csr_io) begin
            s_next.kind     = PTCF_K_CSR;
            s_next.devsel_n = 1'b0;
            s_next.ctl_oe   = 1'b1;
            s_next.st       = PTCF_DATA;
          end else if (hit_flash) begin
            s_next.kind     = PTCF_K_FLASH;
            s_next.devsel_n = 1'b0;
            s_next.ctl_oe   = 1'b1;
            s_next.st       = PTCF_FWAIT;
          end                                                  // [RL22]
        end
      end
      // Register or config data phase, zero wait
      PTCF_DATA: begin
        s_next.oe     = !s_reg.wr;
        s_next.stop_n = 1'b0;                                  // [RL10] [RL11]
        if (s_reg.kind == PTCF_K_CFG && !eeprom_done_in) begin
          s_next.devsel_n = 1'b0;                              // [RL20]
          s_next.st       = PTCF_DONE;
        end else begin
          s_next.trdy_n = 1'b0;                                // [RL9] [RL21]
          s_next.dout   = (s_reg.kind == PTCF_K_CFG) ?
                          cfg_rdata_out : mem_rdata;
          s_next.st     = PTCF_DONE;
        end
      end
      // Flash strobe held for the flash access time
      PTCF_FWAIT: begin
        s_next.faddr  = s_reg.addr[PTCF_FLASH_AW-1:0];
        s_next.fwdata = ad_in[7:0];                            // [RL18]
        s_next.foe_n  = s_reg.wr;
        s_next.fwe_n  = !(s_reg.wr && !irdy_n_in);             // [RL12]
        if (!s_reg.wr || !irdy_n_in) begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
        if (s_reg.cnt == PTCF_CNT_W'(FLASH_WAIT)) begin
          s_next.trdy_n = 1'b0;                                // [RL15] [RL17]
          s_next.stop_n = 1'b0;                                // [RL14]
          s_next.oe     = !s_reg.wr;
          s_next.dout   = {16'h0000, s_reg.addr[0] ?
                           {8'h00, flash_rdata_in[15:8]} :
                           flash_rdata_in};                    // [RL16]
          s_next.st     = PTCF_DONE;
        end
      end
      // Hold until IRDY# completes phase and FRAME# is up
      PTCF_DONE: begin
        if (xfer || (s_reg.trdy_n && frame_n_in)) begin
          s_next.trdy_n   = 1'b1;                              // [RL13]
          s_next.devsel_n = 1'b1;
          s_next.oe       = 1'b0;
          s_next.foe_n    = 1'b1;
          s_next.fwe_n    = 1'b1;
          if (frame_n_in) begin
            s_next.stop_n = 1'b1;
            s_next.st     = PTCF_TURN;
          end
        end else if (!s_reg.trdy_n || !frame_n_in) begin
          s_next.st = PTCF_DONE;
        end
        if (s_reg.trdy_n && s_reg.devsel_n && frame_n_in) begin
          s_next.stop_n = 1'b1;
          s_next.st     = PTCF_TURN;
        end
      end
      // Turnaround, release control lines
      PTCF_TURN: begin
        s_next.stop_n = 1'b1;
        s_next.ctl_oe = 1'b0;
        s_next.st     = PTCF_IDLE;
      end
      default: s_next.st = PTCF_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_reg          <= '0;
      s_reg.st       <= PTCF_IDLE;
      s_reg.trdy_n   <= 1'b1;
      s_reg.stop_n   <= 1'b1;
      s_reg.devsel_n <= 1'b1;
      s_reg.foe_n    <= 1'b1;
      s_reg.fwe_n    <= 1'b1;
      s_reg.frame_q  <= 1'b1;
      s_reg.alt_sync <= 2'b11;
      s_reg.iso_sync <= 2'b11;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs from state; config read data tied to zero
  assign ad_out          = s_reg.dout;
  assign ad_oe_out       = s_reg.oe;
  assign trdy_n_out      = s_reg.trdy_n;
  assign stop_n_out      = s_reg.stop_n;
  assign devsel_n_out    = s_reg.devsel_n;
  assign ctl_oe_out      = s_reg.ctl_oe;
  assign flash_addr_out  = s_reg.faddr;
  assign flash_wdata_out = s_reg.fwdata;
  assign flash_oe_n_out  = s_reg.foe_n;
  assign flash_we_n_out  = s_reg.fwe_n;
  assign cfg_rdata_out   = 32'h0000_0000;

  // Checks
  sequence s_claim_csr;
    s_reg.st == PTCF_DATA && s_reg.kind == PTCF_K_CSR;
  endsequence
  a_csr_zero_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_claim_csr |=> !trdy_n_out && !stop_n_out) // [RL9]
    else $error("register phase not zero wait");
  a_reg_stop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !trdy_n_out && s_reg.kind == PTCF_K_CSR |-> !stop_n_out) // [RL10]
    else $error("register phase without stop");
  a_flash_stop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !trdy_n_out && s_reg.kind == PTCF_K_FLASH |-> !stop_n_out) // [RL14]
    else $error("flash phase without stop");
  a_flash_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(s_reg.st == PTCF_FWAIT) && !s_reg.wr |->
    trdy_n_out [*2]) // [RL15]
    else $error("flash read ready too early");
  a_cfg_retry: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_reg.st == PTCF_DATA && s_reg.kind == PTCF_K_CFG && !eeprom_done_in
    |=> trdy_n_out && !stop_n_out) // [RL20]
    else $error("config not retried");
  a_unclaimed: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_reg.st == PTCF_IDLE && addr_phase && !hit_cfg && !hit_csr_mem &&
    !hit_csr_io && !hit_flash |=> devsel_n_out) // [RL22]
    else $error("claimed unmapped address");
  a_sel_keeps_mac: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sel_reset_in && !sw_reset_in && !d3_to_d0_in && !alt_rst && !iso_rst
    |-> !mac_cfg_rst_out && ptr_rst_out) // [RL3]
    else $error("selective reset touched mac config");
  a_pm_aux: assert property (@(posedge clk_sys_in)
    rst_in && aux_power_in && !alt_rst |-> !pm_evt_rst_out) // [RL6]
    else $error("pm cleared with aux power");
  a_iso_ptr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    iso_rst && !alt_rst && !d3_to_d0_in && !sw_reset_in && !sel_reset_in
    |-> !ptr_rst_out && pci_cfg_rst_out && eeprom_load_out) // [RL4]
    else $error("bus_n_a reset fan-out wrong");
  // Ready and stop together end a claimed data phase
  sequence s_ready_stop;
    !trdy_n_out && !stop_n_out;
  endsequence
  // Flash wait count has reached its end
  sequence s_flash_ripe;
    s_reg.st == PTCF_FWAIT && s_reg.cnt == PTCF_CNT_W'(FLASH_WAIT);
  endsequence
  // Register write disconnects after its single phase
  a_reg_wr_stop: assert property ( // [RL11]
    @(posedge clk_sys_in) disable iff (rst_in)
    s_reg.st == PTCF_DATA && s_reg.kind == PTCF_K_CSR && s_reg.wr
    |=> s_ready_stop)
    else $error("register write without disconnect");
  // Flash phase ends as soon as the wait runs out
  a_flash_end: assert property ( // [RL15]
    @(posedge clk_sys_in) disable iff (rst_in)
    s_flash_ripe |=> s_ready_stop)
    else $error("flash wait overrun");
  // One flash transfer, then the claim is dropped
  a_flash_single: assert property ( // [RL14]
    @(posedge clk_sys_in) disable iff (rst_in)
    xfer && s_reg.kind == PTCF_K_FLASH |=> trdy_n_out && devsel_n_out)
    else $error("flash burst continued");
  // Ready stands until the initiator is ready too
  a_trdy_stands: assert property ( // [RL13]
    @(posedge clk_sys_in) disable iff (rst_in)
    s_reg.st == PTCF_DONE && !trdy_n_out && irdy_n_in |=> !trdy_n_out)
    else $error("ready dropped before transfer");
  // Flash write acknowledged only after the write strobe
  a_flash_wr_done: assert property ( // [RL17]
    @(posedge clk_sys_in) disable iff (rst_in)
    $fell(trdy_n_out) && s_reg.kind == PTCF_K_FLASH && s_reg.wr
    |-> !$past(flash_we_n_out))
    else $error("flash write acknowledged early");
  // Flash read data is at most one word wide
  a_flash_rd_word: assert property ( // [RL16]
    @(posedge clk_sys_in) disable iff (rst_in)
    $fell(trdy_n_out) && s_reg.kind == PTCF_K_FLASH && !s_reg.wr
    |-> ad_oe_out && ad_out[31:16] == 16'h0000)
    else $error("flash read data too wide");
  // Configuration cycles after the load complete with disconnect
  a_cfg_honour: assert property ( // [RL21]
    @(posedge clk_sys_in) disable iff (rst_in)
    s_reg.st == PTCF_DATA && s_reg.kind == PTCF_K_CFG && eeprom_done_in
    |=> s_ready_stop)
    else $error("config cycle not completed");
  // Register window hits are claimed
  a_csr_claim: assert property ( // [RL7]
    @(posedge clk_sys_in) disable iff (rst_in)
    s_reg.st == PTCF_IDLE && addr_phase && (hit_csr_mem || hit_csr_io)
    |=> !devsel_n_out)
    else $error("register window not claimed");
  // Read data is driven whenever ready is shown
  a_rd_drive: assert property ( // [RL10]
    @(posedge clk_sys_in) disable iff (rst_in)
    !trdy_n_out && !s_reg.wr |-> ad_oe_out)
    else $error("read ready without data drive");
  // Software sources never start the EEPROM load
  a_eeprom_src: assert property ( // [RL2]
    @(posedge clk_sys_in) disable iff (rst_in)
    !alt_rst && !iso_rst && (d3_to_d0_in || sw_reset_in || sel_reset_in)
    |-> !eeprom_load_out)
    else $error("eeprom load from software source");
  // Configuration registers survive software and selective resets, but not d3_to_d0_in
  a_cfg_keep: assert property ( // [RL5]
    @(posedge clk_sys_in) disable iff (rst_in)
    !alt_rst && !iso_rst && !d3_to_d0_in |-> !pci_cfg_rst_out)
    else $error("config registers reset by software");
  // Top-ranked source resets every unit
  a_alt_all: assert property ( // [RL1]
    @(posedge clk_sys_in) disable iff (rst_in)
    alt_rst |-> eeprom_load_out && mac_cfg_rst_out && ptr_rst_out &&
    pci_cfg_rst_out && pm_evt_rst_out)
    else $error("alternate reset missed a unit");
endmodule : ptcf_target

/* bench/ptcf_host.sv */
// Behavioural PCI initiator standing in for the host CPU.
`timescale 1ns/1ns
module ptcf_host (
  input  wire logic        clk_sys_in,   // Bus clock
  input  wire logic [31:0] ad_in,        // Target read data
  input  wire logic        trdy_n_in,    // Target ready
  input  wire logic        stop_n_in,    // Target stop
  input  wire logic        devsel_n_in,  // Target claim
  output logic             frame_n_out,  // Frame
  output logic             irdy_n_out,   // Initiator ready
  output logic      [3:0]  cbe_n_out,    // Command, byte enables
  output logic      [31:0] ad_out,       // Address, write data
  output logic             idsel_out     // Config select
);
  logic [31:0] r_data;  // Captured read data
  int          r_lat;   // Edges from address to completion
  logic        r_trdy;  // Ended with TRDY
  logic        r_stop;  // Ended with STOP
  logic        r_dev;   // Claim seen
  // Idle bus
  initial begin
    frame_n_out = 1'b1;
    irdy_n_out  = 1'b1;
    cbe_n_out   = 4'hF;
    ad_out      = 32'h0000_0000;
    idsel_out   = 1'b0;
  end
  // One single-phase cycle, iw clocks before IRDY
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
                      input logic [31:0] wd, input int iw,
                      input logic sel);
    @(posedge clk_sys_in);
    frame_n_out <= 1'b0;
    cbe_n_out   <= cmd;
    ad_out      <= addr;
    idsel_out   <= sel;
    r_dev = 1'b0;
    r_lat = 0;
    for (int n = 1; n < 40 && r_lat == 0; n++) begin
      @(posedge clk_sys_in);
      if (devsel_n_in === 1'b0) r_dev = 1'b1;
      // Completion, retry or master abort after 6 clocks
      if (irdy_n_out === 1'b0 && (trdy_n_in === 1'b0 ||
          stop_n_in === 1'b0 || (n > 6 && !r_dev))) begin
        r_lat = n;
        r_data = ad_in;
        r_trdy = !trdy_n_in;
        r_stop = !stop_n_in;
        irdy_n_out <= 1'b1;
        ad_out     <= ~ad_out;
        cbe_n_out  <= 4'hF;
        idsel_out  <= 1'b0;
      end else if (n == iw + 1) begin
        frame_n_out <= 1'b1;  // Last phase starts with IRDY
        irdy_n_out  <= 1'b0;
        cbe_n_out   <= 4'h0;
        ad_out      <= wd;    // Write data valid with IRDY
      end else if (irdy_n_out) begin
        // Write data stands while IRDY is low
        ad_out <= ~ad_out;  // Undriven AD never holds a value
      end
    end
    repeat (2) @(posedge clk_sys_in);
  endtask : xfer
endmodule : ptcf_host

/* bench/ptcf_target_bench.sv */
// Self-checking bench for the PCI target port and reset splitter.
`timescale 1ns/1ns
module ptcf_target_bench;
  import ptcf_pkg::*;
  localparam int FW = 2;  // Shortened flash wait
  localparam logic [31:0] MB = 32'h0001_0000;  // Register memory base
  localparam logic [31:0] IB = 32'h0000_1000;  // Register I/O base
  localparam logic [31:0] FB = 32'h0004_0000;  // Flash base
  logic clk_sys_in = 0, rst_in = 1, alt_n = 1, iso_n = 1, aux = 0, eed = 0;
  logic d3 = 0, swr = 0, selr = 0, frame_n, irdy_n, idsel, trdy_n, stop_n;
  logic devsel_n, fl_oe_n, fl_we_n, eeld, macr, ptrr, cfgr, pmr, ad_oe, ctl_oe;
  logic [1:0] oes;  // Drive enables seen with ready
  logic [3:0] cbe_n;
  logic [31:0] ad, ad_o;
  logic [16:0] fl_a, wa;
  logic [15:0] fl_d;
  logic [7:0] fl_w, wb;
  int err_count = 0, checks = 0;
  int wcnt = 0, w0;  // Flash write strobe count
  // 20 MHz clock
  always #25 clk_sys_in = ~clk_sys_in;
  // Flash contents follow the address; inverse while not enabled
  function automatic logic [15:0] fdat(input logic [16:0] a);
    return {a[8:1], ~a[8:1]};
  endfunction : fdat
  assign fl_d = fl_oe_n ? ~fdat(fl_a) : fdat(fl_a);
  // Records flash write strobes
  always @(posedge clk_sys_in) if (fl_we_n === 1'b0) begin
    wcnt  <= wcnt + 1;
    wa    <= fl_a;
    wb    <= fl_w;
  end
  // Records drive enables while ready is shown
  always @(posedge clk_sys_in) if (trdy_n === 1'b0) oes <= {ad_oe, ctl_oe};
  ptcf_host host (.clk_sys_in(clk_sys_in), .ad_in(ad_o), .trdy_n_in(trdy_n),
    .stop_n_in(stop_n), .devsel_n_in(devsel_n), .frame_n_out(frame_n),
    .irdy_n_out(irdy_n), .cbe_n_out(cbe_n), .ad_out(ad), .idsel_out(idsel));
  ptcf_target #(.FLASH_WAIT(FW)) DUT (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .alternate_reset_n_in(alt_n), .bus_n_a_in(iso_n),
    .d3_to_d0_in(d3), .sw_reset_in(swr), .sel_reset_in(selr),
    .aux_power_in(aux), .eeprom_done_in(eed), .csr_mem_base_in(MB),
    .csr_io_base_in(IB), .flash_base_in(FB), .idsel_in(idsel),
    .frame_n_in(frame_n), .irdy_n_in(irdy_n), .cbe_n_in(cbe_n),
    .ad_in(ad), .ad_out(ad_o), .ad_oe_out(ad_oe), .trdy_n_out(trdy_n),
    .stop_n_out(stop_n), .devsel_n_out(devsel_n), .ctl_oe_out(ctl_oe),
    .flash_rdata_in(fl_d), .flash_addr_out(fl_a), .flash_wdata_out(fl_w),
    .flash_oe_n_out(fl_oe_n), .flash_we_n_out(fl_we_n), .cfg_rdata_out(),
    .eeprom_load_out(eeld), .mac_cfg_rst_out(macr), .ptr_rst_out(ptrr),
    .pci_cfg_rst_out(cfgr), .pm_evt_rst_out(pmr));
  // Compares one result
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Config retried before the EEPROM load, honoured after
  task automatic t_cfg;
    host.xfer(PTCF_CMD_CFG_RD, 32'h0, 32'h0, 0, 1'b1);
    chk({host.r_trdy, host.r_stop}, 2'b01);
    eed <= 1'b1;
    host.xfer(PTCF_CMD_CFG_RD, 32'h4, 32'h0, 0, 1'b1);
    chk({host.r_trdy, host.r_stop, host.r_data}, {2'b11, 32'h0});
    chk({ad_oe, ctl_oe}, 2'b00);
  endtask : t_cfg
  // Back-to-back register writes, one stretched, then read back
  task automatic t_csr(input logic [3:0] wc, rc, input logic [31:0] b, k);
    host.xfer(wc, b + 32'h4, 32'hA5C3_0F18 ^ k, 0, 1'b0);
    chk({host.r_dev, host.r_trdy, host.r_stop, host.r_lat[5:0]},
        {3'b111, 6'd3});
    host.xfer(wc, b + 32'h8, 32'h5A3C_F0E7 ^ k, 3, 1'b0);
    chk({host.r_trdy, host.r_stop, host.r_lat[5:0]}, {2'b11, 6'd5});
    host.xfer(rc, b + 32'h4, ~b, 0, 1'b0);
    chk({host.r_trdy, host.r_stop, host.r_data},
        {2'b11, 32'hA5C3_0F18 ^ k});
    chk(oes, 2'b11);
    host.xfer(rc, b + 32'h8, ~b, 0, 1'b0);
    chk({host.r_lat[5:0], host.r_data}, {6'd3, 32'h5A3C_F0E7 ^ k});
  endtask : t_csr
  // Flash word and byte reads, byte write
  task automatic t_flash;
    host.xfer(PTCF_CMD_MEM_RD, FB + 32'h0_2346, ~FB, 0, 1'b0);
    chk({host.r_trdy, host.r_stop, host.r_lat[5:0], host.r_data[15:0]},
        {2'b11, 6'(FW + 3), fdat(17'h0_2346)});
    host.xfer(PTCF_CMD_MEM_RD, FB + 32'h1_0A51, ~FB, 0, 1'b0);
    chk({host.r_stop, host.r_data[7:0]},
        {1'b1, 8'(fdat(17'h1_0A51) >> 8)});
    w0 = wcnt;
    host.xfer(PTCF_CMD_MEM_WR, FB + 32'h1_7731, 32'h0000_005E, 0, 1'b0);
    chk({host.r_trdy, host.r_stop, host.r_lat >= FW + 3, wcnt != w0, wa, wb},
        {4'hF, 17'h1_7731, 8'h5E});
  endtask : t_flash
  // Addresses just past each window stay unclaimed
  task automatic t_unmap;
    host.xfer(PTCF_CMD_MEM_RD, FB + 32'h2_0000, 32'h0, 0, 1'b0);
    chk({host.r_dev, host.r_trdy}, 2'b00);
    host.xfer(PTCF_CMD_MEM_WR, MB + 32'h1000, 32'h0, 0, 1'b0);
    chk({host.r_dev, host.r_trdy}, 2'b00);
    host.xfer(PTCF_CMD_IO_RD, IB + 32'h40, 32'h0, 0, 1'b0);
    chk({host.r_dev, host.r_trdy}, 2'b00);
  endtask : t_unmap
  // Each reset source against the units it clears
  task automatic t_rst;
    logic [4:0] tb [7] = '{5'b11111, 5'b11111, 5'b11110, 5'b11010,
                           5'b01110, 5'b01100, 5'b00100};
    for (int s = 0; s < 7; s++) begin
      aux    <= (s == 2);
      alt_n  <= (s != 0);
      rst_in <= (s == 1 || s == 2);
      iso_n  <= (s != 3);
      d3     <= (s == 4);
      swr    <= (s == 5);
      selr   <= (s == 6);
      repeat (4) @(posedge clk_sys_in);
      chk({eeld, macr, ptrr, cfgr, pmr}, tb[s]);
      {alt_n, iso_n} <= 2'b11;
      {rst_in, d3, swr, selr} <= 4'h0;
      repeat (4) @(posedge clk_sys_in);
      chk({eeld, macr, ptrr, cfgr, pmr}, 5'b0);
    end
  endtask : t_rst
  // Prints the verdict and ends the run
  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_cfg;
    t_csr(PTCF_CMD_MEM_WR, PTCF_CMD_MEM_RD, MB, 32'h0);
    t_csr(PTCF_CMD_IO_WR, PTCF_CMD_IO_RD, IB, 32'hFFFF_0000);
    t_flash;
    t_unmap;
    t_rst;
    tally_and_finish;
  end
endmodule : ptcf_target_bench
